// ---- rtl/asq_sequencer.v ----
/*
  serial control and sequencing logic of an eight-input successive
  approximation converter: start-bit detection, configuration byte,
  track/hold timing, conversion on the serial clock or on an internal
  timer, completion strobe and msb-first result shifting.
  assumes cs_n, sclk, din and the comparator come from outside mclk's
  domain; the analog mux, dac and comparator sit outside this module.
*/
// Functional notes
// - capture din on each sclk rise, cs low
// - cs fall starts nothing; first one is bit7
// - bits 6..4 choose converter inputs
// - bit 3 picks unipolar or bipolar range
// - bit 2: shared return or paired difference
// - single-ended positive index from pick bits
// - differential pairs, pick2 swaps polarity
// - low two bits: power and clock code
// - track during last three bits, hold after
// - conversion starts on fall after bit eight
// - external mode: strobe high one sclk period
// - external mode: twelve decisions on falls
// - external mode: cs high floats strobe, dout
// - internal mode: strobe low at most 7.5us, longer while the fifo is full
// - internal mode: result held, msb after strobe
// - internal mode: cs high spares conversion, strobe
// - data on falls; straight binary or twos
// - result framed by zero, sub-lsb, trailing zeros
// - new start only after bit 3 shown
// - cs toggle abandons external conversion, next one restarts
// - reset: internal mode, strobe high, zeros out
// - power code: convert first, then power down
`timescale 1ns/1ns
`default_nettype none
`include "asq_regs.vh"
module asq_sequencer (
  input  wire        mclk,               // 25 mhz system clock
  input  wire        nrst,               // synchronous reset, active low
  input  wire        clk_en,             // freezes all state while low
  input  wire        cs_n,               // chip select pin, active low
  input  wire        sclk,               // serial clock pin
  input  wire        din,                // serial data in pin
  input  wire        cmp_hi,             // comparator: input above trial
  input  wire        res_ready,          // result stream consumer ready
  output reg         dout,               // serial data out
  output reg         dout_oe_n,          // dout enable, low drives
  output reg         completion_strobe,  // completion strobe level
  output reg         strobe_oe_n,        // strobe enable, low drives
  output reg         th_track,           // track/hold: high tracks
  output reg  [11:0] dac_code,           // trial code to the dac
  output reg  [3:0]  pos_sel,            // positive input select
  output reg  [3:0]  neg_sel,            // negative input, 8 is shared
  output reg         polarity_mode,      // high unipolar, low bipolar
  output reg         pwr_full_dn,        // full power-down active
  output reg         pwr_fast_dn,        // fast power-down active
  output wire [11:0] res_data,           // result stream word
  output wire        res_valid,          // result stream valid
  output reg         res_drop            // result lost, fifo full
);

  localparam ST_IDLE = 2'h0;             // no conversion running
  localparam ST_EXT  = 2'h1;             // decisions on sclk falls
  localparam ST_INT  = 2'h2;             // decisions on internal timer
  localparam ST_PUSH = 2'h3;             // internal result waits for fifo

  // pin synchronisers, two flops each
  reg [1:0] s_sclk;                      // sclk synchroniser
  reg [1:0] s_cs;                        // cs_n synchroniser
  reg [1:0] s_din;                       // din synchroniser
  reg [1:0] s_cmp;                       // comparator synchroniser
  reg       sclk_d;                      // previous synced sclk
  reg       cs_d;                        // previous synced cs_n

  // receiver
  reg       rx_on;                       // start bit seen, shifting
  reg [2:0] rx_cnt;                      // bits after the start bit
  reg [5:0] rx_sr;                       // bits received so far
  reg [7:0] conversion_config_byte;      // last complete byte
  reg       armed;                       // byte done, waits for fall
  reg       trk_pend;                    // start tracking at next fall

  // converter
  reg [1:0]  st;                         // converter state
  reg        ext_mode;                   // clock mode in force
  reg [11:0] mask;                       // bit under decision
  reg [7:0]  step_cnt;                   // internal step timer
  reg [3:0]  shown;                      // bits put on dout
  reg        cs_tog;                     // cs went high mid conversion
  reg        pd_req;                     // power down after this one
  reg        pd_fast;                    // requested power-down is fast
  reg [11:0] held;                       // held result
  reg [11:0] out_sr;                     // result shift register
  reg        push_v;                     // result offered to fifo
  wire       fifo_rdy;                   // fifo has room

  wire sclk_rise = s_sclk[1] & ~sclk_d;  // edges of the synced clock
  wire sclk_fall = ~s_sclk[1] & sclk_d;
  wire cs_low    = ~s_cs[1];
  wire cs_rise   = s_cs[1] & ~cs_d;
  wire cs_fall   = ~s_cs[1] & cs_d;
  wire bipolar   = ~polarity_mode;

  // decision at the current bit, and its formatted output bit
  wire [11:0] sar_keep = s_cmp[1] ? dac_code : (dac_code & ~mask);
  wire [11:0] res_fmt  = bipolar ? {~sar_keep[11], sar_keep[10:0]} : sar_keep;
  wire        dec_bit  = (mask[11] & bipolar) ? ~s_cmp[1] : s_cmp[1];
  wire        last_dec = mask[0];

  // a new start bit is taken when idle, past bit 3, or after a cs toggle
  wire start_ok = (st == ST_IDLE) || (shown >= `ASQ_START_OK_CNT) || cs_tog;
  // next clock mode: power codes keep the mode already in force
  wire next_ext = conversion_config_byte[`ASQ_CFG_PWR_HI] ?
                  conversion_config_byte[`ASQ_CFG_PWR_LO] : ext_mode;

  // synchronisers and edge history
  always @(posedge mclk) begin
    if (!nrst) begin
      s_sclk <= 2'h0;
      s_cs   <= 2'h3;
      s_din  <= 2'h0;
      s_cmp  <= 2'h0;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else if (clk_en) begin
      s_sclk <= {s_sclk[0], sclk};
      s_cs   <= {s_cs[0], cs_n};
      s_din  <= {s_din[0], din};
      s_cmp  <= {s_cmp[0], cmp_hi};
      sclk_d <= s_sclk[1];
      cs_d   <= s_cs[1];
    end
  end

  // receiver: start bit, configuration byte, mux select, tracking
  always @(posedge mclk) begin
    if (!nrst) begin
      rx_on                  <= 1'b0;
      rx_cnt                 <= 3'h0;
      rx_sr                  <= 6'h00;
      conversion_config_byte <= `ASQ_CFG_RESET;
      pos_sel                <= 4'h0;
      neg_sel                <= `ASQ_SEL_SHARED;
      polarity_mode          <= 1'b1;
      trk_pend               <= 1'b0;
    end else if (clk_en) begin
      if (cs_rise) begin
        rx_on    <= 1'b0;              // cs high blocks input
        trk_pend <= 1'b0;
      end else if (sclk_rise && cs_low) begin
        if (!rx_on) begin
          // zeros before the start bit do nothing
          if (s_din[1] && start_ok) begin
            rx_on  <= 1'b1;
            rx_cnt <= 3'h0;
          end
        end else begin
          rx_sr  <= {rx_sr[4:0], s_din[1]};
          rx_cnt <= rx_cnt + 3'h1;
          if (rx_cnt == `ASQ_RX_PICKS) begin
            // positive side is the same index in both input modes
            pos_sel <= {1'b0, rx_sr[0], s_din[1], rx_sr[1]};
          end
          if (rx_cnt == `ASQ_RX_POLARITY) begin
            polarity_mode <= s_din[1];
            trk_pend      <= 1'b1;      // fifth bit in, track from next fall
          end
          if (rx_cnt == `ASQ_RX_INPUT) begin
            // shared return, or the partner of the pair
            neg_sel <= s_din[1] ? `ASQ_SEL_SHARED : {1'b0, rx_sr[2], rx_sr[1], ~rx_sr[3]};
          end
          if (rx_cnt == `ASQ_RX_LAST) begin
            conversion_config_byte <= {1'b1, rx_sr, s_din[1]};
            rx_on                  <= 1'b0;
          end
        end
      end else if (sclk_fall) begin
        trk_pend <= 1'b0;
      end
    end
  end

  // converter, strobe, output shifting and power state
  always @(posedge mclk) begin
    if (!nrst) begin
      st                <= ST_IDLE;
      ext_mode          <= 1'b0;      // internal mode at power-on
      armed             <= 1'b0;
      mask              <= 12'h000;
      dac_code          <= 12'h000;
      step_cnt          <= 8'h00;
      shown             <= 4'h0;
      cs_tog            <= 1'b0;
      pd_req            <= 1'b0;
      pd_fast           <= 1'b0;
      held              <= `ASQ_RES_RESET;
      out_sr            <= 12'h000;  // shifts zeros until a result
      push_v            <= 1'b0;
      res_drop          <= 1'b0;
      dout              <= 1'b0;
      dout_oe_n         <= 1'b1;
      completion_strobe <= 1'b1;
      strobe_oe_n       <= 1'b0;
      th_track          <= 1'b0;
      pwr_full_dn       <= 1'b0;
      pwr_fast_dn       <= 1'b0;
    end else if (clk_en) begin
      res_drop  <= 1'b0;
      dout_oe_n <= s_cs[1];           // dout floats while cs high
      // the eighth bit arms the converter; the start bit powers up
      if (sclk_rise && cs_low && rx_on && rx_cnt == `ASQ_RX_LAST)
        armed <= 1'b1;
      if (sclk_rise && cs_low && !rx_on && s_din[1] && start_ok) begin
        pwr_full_dn <= 1'b0;
        pwr_fast_dn <= 1'b0;
      end
      if (sclk_fall && trk_pend)
        th_track <= 1'b1;
      // strobe drive: external mode floats it with cs high
      if (cs_rise && ext_mode) begin
        strobe_oe_n <= 1'b1;
      end else if (cs_fall) begin
        strobe_oe_n <= 1'b0;
        if (ext_mode)
          completion_strobe <= 1'b0;
      end
      if (cs_rise && st != ST_IDLE)
        cs_tog <= 1'b1;
      // fifo hand-off: external results cannot wait, so a full fifo drops
      if (push_v && fifo_rdy) begin
        push_v <= 1'b0;
      end else if (push_v && st != ST_PUSH) begin
        push_v   <= 1'b0;
        res_drop <= 1'b1;
      end
      if (cs_rise && armed) begin
        armed <= 1'b0;                // byte torn by cs
      end else if (sclk_fall && armed) begin
        // conversion begins here; hold the sample
        armed    <= 1'b0;
        th_track <= 1'b0;
        ext_mode <= next_ext;
        pd_req   <= ~conversion_config_byte[`ASQ_CFG_PWR_HI];
        pd_fast  <= conversion_config_byte[`ASQ_CFG_PWR_LO];
        mask     <= `ASQ_SAR_MSB;
        dac_code <= `ASQ_SAR_MSB;
        shown    <= 4'h0;
        cs_tog   <= 1'b0;
        step_cnt <= 8'h00;
        out_sr   <= 12'h000;
        dout     <= 1'b0;             // leading zero
        if (next_ext) begin
          st                <= ST_EXT;
          completion_strobe <= 1'b1;  // one sclk period high
          strobe_oe_n       <= 1'b0;
        end else begin
          st                <= ST_INT;
          completion_strobe <= 1'b0;  // low while converting
          strobe_oe_n       <= 1'b0;
        end
      end else begin
        case (st)
          ST_EXT: begin
            if (cs_rise) begin
              st <= ST_IDLE;          // abandoned
            end else if (sclk_fall) begin
              // one decision per fall, shown at once
              completion_strobe <= 1'b0;
              dout     <= dec_bit;
              shown    <= shown + 4'h1;
              mask     <= {1'b0, mask[11:1]};
              dac_code <= sar_keep | {1'b0, mask[11:1]};
              if (last_dec) begin
                held        <= res_fmt;
                push_v      <= 1'b1;
                st          <= ST_IDLE;  // trailing zeros follow
                pwr_full_dn <= pd_req & ~pd_fast;
                pwr_fast_dn <= pd_req & pd_fast;
              end
            end
          end
          ST_INT: begin
            // internal timer, cs high leaves it alone
            if (step_cnt == `ASQ_STEP_LAST) begin
              step_cnt <= 8'h00;
              mask     <= {1'b0, mask[11:1]};
              dac_code <= sar_keep | {1'b0, mask[11:1]};
              if (last_dec) begin
                held   <= res_fmt;
                push_v <= 1'b1;
                st     <= ST_PUSH;
              end
            end else begin
              step_cnt <= step_cnt + 8'h01;
            end
            if (sclk_fall) begin
              dout   <= out_sr[11];
              out_sr <= {out_sr[10:0], 1'b0};
            end
          end
          ST_PUSH: begin
            // strobe rises once the fifo takes the word
            if (fifo_rdy) begin
              completion_strobe <= 1'b1;
              out_sr            <= held;
              st                <= ST_IDLE;
              pwr_full_dn       <= pd_req & ~pd_fast;
              pwr_fast_dn       <= pd_req & pd_fast;
            end
          end
          default: begin
            // idle: falls shift out_sr msb first, the held result after an internal conversion, then zeros
            if (sclk_fall) begin
              dout   <= out_sr[11];
              out_sr <= {out_sr[10:0], 1'b0};
              if (shown != 4'hf)
                shown <= shown + 4'h1;
            end
          end
        endcase
      end
    end
  end

  // result stream; back-pressure stalls internal completion
  asq_fifo #(
    .W  (`ASQ_SAR_BITS),
    .D  (`ASQ_FIFO_DEPTH),
    .AW (`ASQ_FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (push_v),
    .in_data   (held),
    .in_ready  (fifo_rdy),
    .out_valid (res_valid),
    .out_data  (res_data),
    .out_ready (res_ready)
  );

endmodule // asq_sequencer
`default_nettype wire

// ---- rtl/asq_regs.vh ----
/*
  constants of the serial control sequencer: configuration byte fields,
  power/clock codes, reset values and internal conversion timing.
  assumes the includer runs on the 25 MHz mclk.
*/
`ifndef ASQ_REGS_VH
`define ASQ_REGS_VH

// configuration byte field positions
`define ASQ_CFG_START      7
`define ASQ_CFG_PICK2      6
`define ASQ_CFG_PICK1      5
`define ASQ_CFG_PICK0      4
`define ASQ_CFG_POLARITY   3
`define ASQ_CFG_INPUT      2
`define ASQ_CFG_PWR_HI     1
`define ASQ_CFG_PWR_LO     0

// power / clock codes
`define ASQ_PWR_FULL_DN    2'h0
`define ASQ_PWR_FAST_DN    2'h1
`define ASQ_PWR_INT_CLK    2'h2
`define ASQ_PWR_EXT_CLK    2'h3

// reset state: internal clock, single-ended, input 0
`define ASQ_CFG_RESET      8'h06
`define ASQ_RES_RESET      12'h000

// mux select code of the shared return input
`define ASQ_SEL_SHARED     4'h8

// successive approximation width (10 result bits plus 2 sub-lsb bits)
`define ASQ_SAR_BITS       12
`define ASQ_SAR_MSB        12'h800
// decisions shown before a new start bit is accepted (through bit 3)
`define ASQ_START_OK_CNT   4'h7
// receiver bit counts after the start bit
`define ASQ_RX_PICKS       3'h2
`define ASQ_RX_POLARITY    3'h3
`define ASQ_RX_INPUT       3'h4
`define ASQ_RX_LAST        3'h6

// internal conversion: longest low time of the strobe
`define ASQ_CONV_MAX_NS    7500
`define ASQ_MCLK_MHZ       25
`define ASQ_CONV_CYC       ((`ASQ_CONV_MAX_NS * `ASQ_MCLK_MHZ) / 1000)
`define ASQ_STEP_LAST      8'h0e  // last count of one step: 187 mclk / 12 steps, minus one

// result fifo
`define ASQ_FIFO_DEPTH     8
`define ASQ_FIFO_AW        3

`endif

// ---- rtl/asq_fifo.v ----
/*
  small result fifo with a registered output stage.
  assumes one clock, synchronous active-low reset, and a clock enable
  that freezes all state.
*/
`timescale 1ns/1ns
`default_nettype none
module asq_fifo #(
  parameter W  = 12,                   // word width
  parameter D  = 8,                    // storage depth, power of two
  parameter AW = 3                     // pointer width, log2 of d
) (
  input  wire         mclk,            // system clock
  input  wire         nrst,            // synchronous reset, active low
  input  wire         clk_en,          // freezes state while low
  input  wire         in_valid,        // write side word offered
  input  wire [W-1:0] in_data,         // write side word
  output wire         in_ready,        // room for a word
  output reg          out_valid,       // read side word present
  output reg  [W-1:0] out_data,        // read side word, registered
  input  wire         out_ready        // reader takes the word
);

  reg [W-1:0] mem [0:D-1];             // storage array
  reg [AW-1:0] wp;                     // write pointer
  reg [AW-1:0] rp;                     // read pointer
  reg [AW:0]   cnt;                    // words held in the array

  wire push = in_valid & in_ready;     // accepted write
  wire pop  = (cnt != {(AW+1){1'b0}}) & (~out_valid | out_ready);  // refill output stage

  // full only when the array holds d words; the output stage adds one more
  assign in_ready = (cnt != D[AW:0]);

  // pointers, count and output stage
  always @(posedge mclk) begin
    if (!nrst) begin
      wp        <= {AW{1'b0}};
      rp        <= {AW{1'b0}};
      cnt       <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        mem[wp] <= in_data;
        wp      <= wp + 1'b1;
      end
      if (pop) begin
        out_data  <= mem[rp];
        out_valid <= 1'b1;
        rp        <= rp + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;             // word taken, nothing behind it
      end
      if (push & ~pop)
        cnt <= cnt + 1'b1;
      else if (pop & ~push)
        cnt <= cnt - 1'b1;
    end
  end

endmodule // asq_fifo
`default_nettype wire

// ---- testbench/asq_host_model.sv ----
/*
  serial master model for the sequencer: mode-zero clocking, msb first.
  assumes the bench calls its tasks from an mclk edge; sclk half period is 4 mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module asq_host_model (
  input  wire logic mclk,      // system clock
  input  wire logic dout,      // device serial out
  input  wire logic dout_oe_n, // device out enable, low drives
  output var  logic cs_n,      // chip select, active low
  output var  logic sclk,      // serial clock, idles low
  output var  logic din        // serial data to the device
);
  // a released line reads high through the pull-up, never the last bit
  wire miso = dout_oe_n ? 1'b1 : dout;

  // idle levels: deselected, clock low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // select or release, then give the synchroniser time to follow
  task automatic sel(input logic on);
    cs_n <= !on;
    repeat (5) @(posedge mclk);
  endtask

  // shift n bits: din moves while sclk is low, dout is taken on the rise
  task automatic shift(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = 24'h0;
    for (int i = n - 1; i >= 0; i--) begin
      din <= tx[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1; // above 100kHz
      rx = {rx[22:0], miso};
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;                      // frames stay far under the droop limit
    end
  endtask
endmodule // asq_host_model
`default_nettype wire

// ---- testbench/asq_sequencer_sva.sv ----
/*
  concurrent checks on the sequencer's ports.
  assumes a bind to asq_sequencer; everything on mclk with sync reset nrst.
*/
`timescale 1ns/1ns
`default_nettype none
module asq_sequencer_sva (
  input wire logic        mclk,              // system clock
  input wire logic        nrst,              // sync reset, active low
  input wire logic        cs_n,              // chip select pin
  input wire logic        sclk,              // serial clock pin
  input wire logic        dout,              // serial out
  input wire logic        dout_oe_n,         // dout enable
  input wire logic        completion_strobe, // strobe level
  input wire logic        strobe_oe_n,       // strobe enable
  input wire logic        th_track,          // track/hold
  input wire logic [11:0] dac_code,          // trial code
  input wire logic [3:0]  pos_sel,           // positive input
  input wire logic [3:0]  neg_sel,           // negative input
  input wire logic        polarity_mode,     // unipolar when high
  input wire logic        pwr_full_dn,       // full power-down
  input wire logic        pwr_fast_dn,       // fast power-down
  input wire logic [11:0] res_data,          // result word
  input wire logic        res_valid,         // result valid
  input wire logic        res_ready          // result taken
);
  // pin edges act through a synchroniser, so checks look back at the pins
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  dout_float_a: assert property (cs_n [*5] |-> dout_oe_n)
    else $error("dout driven while deselected");
  drive_on_a: assert property (!cs_n [*5] |-> !dout_oe_n && !strobe_oe_n)
    else $error("outputs not driven while selected");
  dout_edge_a: assert property ($changed(dout) |-> !$past(sclk, 2) || $past(cs_n, 3))
    else $error("dout moved off a falling edge");
  strobe_edge_a: assert property ($fell(completion_strobe) |->
    !$past(sclk, 2) || $past(strobe_oe_n) || strobe_oe_n) else $error("strobe fell off a falling edge");
  cfg_quiet_a: assert property (cs_n [*5] |->
    $stable(pos_sel) && $stable(neg_sel) && $stable(polarity_mode)) else $error("config moved while deselected");
  hold_edge_a: assert property ($fell(th_track) |-> !$past(sclk, 2))
    else $error("hold began off a falling edge");
  mux_pair_a: assert property ($fell(th_track) |-> (neg_sel == 4'h8) ? (pos_sel < 4'h8) :
    (neg_sel[3:1] == pos_sel[3:1] && neg_sel[0] != pos_sel[0])) else $error("input pair illegal");
  res_hold_a: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
    else $error("result word lost before taken");
  pwr_excl_a: assert property (!(pwr_full_dn && pwr_fast_dn))
    else $error("two power-down modes at once");
  dac_hold_a: assert property ($changed(dac_code) |-> !th_track)
    else $error("trial code moved while tracking");
endmodule // asq_sequencer_sva
`default_nettype wire

// ---- testbench/asq_sequencer_test.sv ----
/*
  self-checking bench for the serial control sequencer.
  assumes design, host model and checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module asq_sequencer_test;
  logic        mclk      = 1'b0;   // 25 mhz system clock
  logic        nrst      = 1'b0;   // sync reset, active low
  logic        cmp_hi    = 1'b0;   // comparator model
  logic        res_ready = 1'b0;   // consumer, stalls at random
  logic        hold_rdy  = 1'b0;   // stall the consumer to fill the fifo
  logic        clk_en    = 1'b1;   // low at random in the last drain
  logic        ext       = 1'b0;   // clock mode the device should be in
  logic [11:0] ain       = 12'h0;  // analog level, offset binary
  logic [31:0] seed      = 32'h53; // xorshift state
  logic [11:0] q[$];               // expected result words, oldest first
  int          error_cnt = 0;      // mismatches
  int          n_tests   = 0;      // comparisons
  int          drops     = 0;      // lost results seen
  wire         cs_n, sclk, din, dout, dout_oe_n, completion_strobe, strobe_oe_n, th_track;
  wire         polarity_mode, pwr_full_dn, pwr_fast_dn, res_valid, res_drop;
  wire  [3:0]  pos_sel, neg_sel;
  wire  [11:0] dac_code, res_data;

  always #20 mclk = ~mclk;

  asq_sequencer i_dut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk), .din(din),
    .cmp_hi(cmp_hi), .res_ready(res_ready), .dout(dout), .dout_oe_n(dout_oe_n),
    .completion_strobe(completion_strobe), .strobe_oe_n(strobe_oe_n), .th_track(th_track),
    .dac_code(dac_code), .pos_sel(pos_sel), .neg_sel(neg_sel), .polarity_mode(polarity_mode),
    .pwr_full_dn(pwr_full_dn), .pwr_fast_dn(pwr_fast_dn), .res_data(res_data), .res_valid(res_valid),
    .res_drop(res_drop));
  asq_host_model i_host (.mclk(mclk), .dout(dout), .dout_oe_n(dout_oe_n), .cs_n(cs_n), .sclk(sclk), .din(din));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // positive index is pick1*4 + pick0*2 + pick2 in both input modes
  function automatic logic [7:0] exp_mux(input logic [7:0] c);
    return {1'b0, c[5], c[4], c[6], c[2] ? 4'h8 : {1'b0, c[5], c[4], ~c[6]}};
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // comparator settles one mclk after a trial; consumer stalls at random
  always @(posedge mclk) begin
    cmp_hi    <= (ain >= dac_code);
    res_ready <= !hold_rdy && (xs() & 32'h1) != 32'h0;
    clk_en    <= hold_rdy || drops == 0 || (xs() & 32'h2) != 32'h0;
  end

  // each word taken off the stream is compared with the oldest note
  always @(posedge mclk) begin
    if (res_drop === 1'b1) drops++;
    if (nrst && clk_en && res_valid === 1'b1 && res_ready === 1'b1) begin
      if (q.size() == 0) chk("res_extra", 16'h1, 16'h0);
      else chk("res_data", res_data, q.pop_front());
    end
  end

  // how: 0 normal, 1 deselect mid conversion, 2 result should be dropped
  task automatic conv(input logic [7:0] cfg, input int how);
    logic [23:0] rx;
    logic [11:0] a, res;
    int          n;
    a = 12'(xs());
    ain <= a;
    if (cfg[1]) ext = cfg[0];                              // power codes keep the clock mode
    res = cfg[3] ? a : {~a[11], a[10:0]};                 // twos complement when bipolar
    if (how == 0) q.push_back(res);
    i_host.sel(1'b1);
    i_host.shift({16'h0, cfg}, 11, rx); // three leading zeros are ignored
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("mux", {pos_sel, neg_sel}, exp_mux(cfg));
    chk("polarity", polarity_mode, cfg[3]);
    if (ext) chk("strobe_hi", completion_strobe, 1'b1);
    @(posedge mclk);
    if (!ext) begin
      i_host.sel(1'b0);                                   // the conversion must survive this
      n = 0;
      while (completion_strobe !== 1'b1 && n < 300) begin
        @(posedge mclk);
        n++;
        if (strobe_oe_n !== 1'b0) chk("strobe_oe", strobe_oe_n, 1'b0);
      end
      chk("conv_time", n <= 181, 1'b1); // low at most 181 mclk after deselect
      i_host.sel(1'b1); // strobe seen
    end
    if (how == 1) begin
      i_host.shift(24'h0, 4, rx);
      i_host.sel(1'b0);
      chk("float", {dout_oe_n, strobe_oe_n}, 2'h3);
      i_host.sel(1'b1);
      chk("strobe_lo", {strobe_oe_n, completion_strobe}, 2'h0);
      i_host.sel(1'b0);
      return;
    end
    i_host.shift(24'h0, 16, rx);                          // two zero bytes
    chk("dout_bits", rx[15:0], {1'b0, res, 3'h0});
    i_host.sel(1'b0);
    chk("pwr", {pwr_full_dn, pwr_fast_dn}, {cfg[1:0] == 2'h0, cfg[1:0] == 2'h1});
  endtask

  task automatic wait_q();
    int n = 0;
    while (q.size() != 0 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    chk("queue_empty", q.size(), 16'h0);
  endtask

  initial begin
    logic [23:0] rx;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("reset_out", {completion_strobe, strobe_oe_n, dout_oe_n, polarity_mode, neg_sel}, 8'hb8);
    i_host.sel(1'b1);
    i_host.shift(24'h0, 16, rx);
    chk("idle_dout", rx[15:0], 16'h0);
    i_host.sel(1'b0);
    $display("test reset done");
    // every pick and input mode; codes run 11, 01, 10, 00
    for (int i = 0; i < 16; i++)
      conv({1'b1, i[2:0], seed[7], i[3], ~i[0], ~i[1]}, 0);
    $display("test config loop done");
    conv(8'hbf, 1);
    conv(8'hbf, 0);
    $display("test abort done");
    wait_q();
    hold_rdy <= 1'b1;
    for (int k = 0; k < 10; k++)
      conv(8'h8f, k < 9 ? 0 : 2);
    chk("res_drop", drops, 16'h1);
    hold_rdy <= 1'b0;
    wait_q();
    $display("test fifo fill done");
    finish_test();
  end

  // watchdog: the run needs some 8000 mclk
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end
endmodule // asq_sequencer_test

bind asq_sequencer asq_sequencer_sva i_sva (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .dout(dout),
  .dout_oe_n(dout_oe_n), .completion_strobe(completion_strobe), .strobe_oe_n(strobe_oe_n),
  .th_track(th_track), .dac_code(dac_code), .pos_sel(pos_sel), .neg_sel(neg_sel),
  .polarity_mode(polarity_mode), .pwr_full_dn(pwr_full_dn), .pwr_fast_dn(pwr_fast_dn),
  .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready));
`default_nettype wire
